//--- verilog/lpi_mem_end.sv
// memory device end: ddr capture of the command bus, masked writes, strobed reads
// Summary of operation
// - command/address captured on both clock edges
// - chip select, clock enable: rising edge only
// - rising edge: true rises, complement falls
// - clock enable low stops buffers, drivers (here command capture and read drive only; strobed write capture is not gated)
// - clock enable transitions mark power-save entry/exit
// - command code from enable, select, bus
// - strobe driven by device on reads
// - read strobe edge-aligned; write strobe centred
// - one strobe per byte lane
// - masked bytes are not stored
// - mask sampled on both strobe edges
// - mask n covers byte lane n
// - mask is input only, no dnv feature
// - data bus 16 or 32 bits bidirectional
// - one command per clock cycle
// - command/address bus ten bits wide
`timescale 1ns/1ps
`default_nettype none
module lpi_mem_end #(
	parameter int DQ_W = lpi_pkg::DQ_W_X16,
	parameter int LANES = lpi_pkg::LANES_X16
) (
	// link to the controller
	lpi_link_if.mem LINK,
	// user side, CLK domain
	input wire logic CLK,
	input wire logic RST_N,
	output logic CMD_VALID,
	input wire logic CMD_READY,
	output logic [2*lpi_pkg::CA_W+1:0] CMD_CODE,
	output logic [DQ_W-1:0] WR_DATA,
	output logic [LANES-1:0] WR_STORE,
	output logic WR_VALID,
	input wire logic [DQ_W-1:0] RD_DATA,
	input wire logic RD_VALID,
	output logic RD_READY,
	output logic POWER_SAVE
);
	import lpi_pkg::*;
	// ************************************
	// link-clock domain
	// ************************************
	logic [CA_W-1:0] ca_rise_reg;
	logic [CA_W-1:0] ca_fall_reg;
	// link side has no reset: its clock stands still while the controller is in reset
	logic cke_reg = 1'b0;
	logic cs_n_reg = 1'b1;
	logic cmd_tgl_reg = 1'b0;
	logic wr_tgl_reg = 1'b0;
	logic [DQ_W-1:0] wd_rise_reg;
	logic [LANES-1:0] wm_rise_reg;
	logic [DQ_W-1:0] wd_word_reg;
	logic [LANES-1:0] wm_word_reg;
	logic [2*CA_W+1:0] cmd_hold_reg;
	logic rd_tgl_sync1_reg = 1'b0;
	logic rd_tgl_sync2_reg = 1'b0;
	logic rd_tgl_seen_reg = 1'b0;
	logic drive_reg = 1'b0;
	logic [DQ_W-1:0] rd_word_reg = '0;
	// launched from the core-clock side, held until the link side echoes the toggle
	logic rd_tgl_reg;
	logic [DQ_W-1:0] rd_data_reg;
	// stopped clock when enable is low: capture gated on the sampled enable
	always_ff @(posedge LINK.ck) begin
		cke_reg <= LINK.cke;
		cs_n_reg <= LINK.cs_n;
		ca_rise_reg <= LINK.cmd_addr_bus;
	end
	// falling edge of ck is the crossing with the complement rising
	always_ff @(negedge LINK.ck) begin
		ca_fall_reg <= LINK.cmd_addr_bus;
	end
	// one command per cycle, assembled at the next rising edge
	always_ff @(posedge LINK.ck) begin
		if (cke_reg && !cs_n_reg) begin
			cmd_hold_reg <= {cke_reg, cs_n_reg, ca_fall_reg, ca_rise_reg};
			cmd_tgl_reg <= ~cmd_tgl_reg;
		end
	end
	// write data taken on the rising strobe edge, mask on each strobe edge; our own read strobe is ignored
	always_ff @(posedge LINK.dqs[0]) begin
		if (!drive_reg) begin
			wd_rise_reg <= LINK.dq;
			wm_rise_reg <= LINK.write_byte_mask;
		end
	end
	always_ff @(negedge LINK.dqs[0]) begin
		if (!drive_reg) begin
			wd_word_reg <= wd_rise_reg;
			wm_word_reg <= wm_rise_reg | LINK.write_byte_mask;
			wr_tgl_reg <= ~wr_tgl_reg;
		end
	end
	// read drive: toggle synchronised on the rising edge
	always_ff @(posedge LINK.ck) begin
		rd_tgl_sync1_reg <= rd_tgl_reg;
		rd_tgl_sync2_reg <= rd_tgl_sync1_reg;
		rd_tgl_seen_reg <= rd_tgl_sync2_reg;
	end
	// drive moves only while ck is low, so the gated strobe cannot glitch
	always_ff @(negedge LINK.ck) begin
		drive_reg <= cke_reg && (rd_tgl_sync2_reg != rd_tgl_seen_reg);
		if (rd_tgl_sync2_reg != rd_tgl_seen_reg) begin
			rd_word_reg <= rd_data_reg;
		end
	end
	assign LINK.dq_mem_oe = drive_reg;
	assign LINK.dq_mem_o = rd_word_reg;
	assign LINK.dqs_mem_oe = drive_reg;
	assign LINK.dqs_mem_o = {LANES{drive_reg & LINK.ck}};
	// ************************************
	// core-clock domain
	// ************************************
	logic [2:0] cmd_sync_reg;
	logic [2:0] wr_sync_reg;
	logic [1:0] cke_sync_reg;
	logic [1:0] buf_cnt_reg;
	logic [2*CA_W+1:0] buf_reg [BUF_DEPTH];
	logic buf_wp_reg;
	logic buf_rp_reg;
	logic cmd_evt;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cmd_sync_reg <= 3'h0;
			wr_sync_reg <= 3'h0;
			cke_sync_reg <= 2'h0;
		end else begin
			cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_tgl_reg};
			wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
			cke_sync_reg <= {cke_sync_reg[0], cke_reg};
		end
	end
	assign cmd_evt = cmd_sync_reg[2] ^ cmd_sync_reg[1];
	assign POWER_SAVE = ~cke_sync_reg[1];
	// two-entry command buffer; commands arriving while full are dropped
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			buf_cnt_reg <= 2'h0;
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
		end else begin
			if (cmd_evt && buf_cnt_reg != 2'h2) begin
				buf_reg[buf_wp_reg] <= cmd_hold_reg;
				buf_wp_reg <= ~buf_wp_reg;
			end
			if (CMD_VALID && CMD_READY) begin
				buf_rp_reg <= ~buf_rp_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + 2'((cmd_evt && buf_cnt_reg != 2'h2) ? 1 : 0)
				- 2'((CMD_VALID && CMD_READY) ? 1 : 0);
		end
	end
	assign CMD_VALID = buf_cnt_reg != 2'h0;
	assign CMD_CODE = buf_reg[buf_rp_reg];
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			WR_VALID <= 1'b0;
			WR_DATA <= '0;
			WR_STORE <= '0;
		end else begin
			WR_VALID <= wr_sync_reg[2] ^ wr_sync_reg[1];
			if (wr_sync_reg[2] ^ wr_sync_reg[1]) begin
				WR_DATA <= wd_word_reg;
				WR_STORE <= ~wm_word_reg;
			end
		end
	end
	// ************************************
	// read return path
	// ************************************
	// two-entry buffer: a word offered while another is still crossing is kept
	logic [DQ_W-1:0] rbuf_reg [BUF_DEPTH];
	logic [1:0] rbuf_cnt_reg;
	logic rbuf_wp_reg;
	logic rbuf_rp_reg;
	logic [1:0] rd_ack_sync_reg;
	logic rd_push;
	logic rd_launch;
	assign RD_READY = rbuf_cnt_reg != 2'h2;
	assign rd_push = RD_VALID && RD_READY;
	// next word leaves only once the link side has echoed the last toggle
	assign rd_launch = rbuf_cnt_reg != 2'h0 && rd_tgl_reg == rd_ack_sync_reg[1];
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rd_ack_sync_reg <= 2'h0;
		end else begin
			rd_ack_sync_reg <= {rd_ack_sync_reg[0], rd_tgl_seen_reg};
		end
	end
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rbuf_cnt_reg <= 2'h0;
			rbuf_wp_reg <= 1'b0;
			rbuf_rp_reg <= 1'b0;
			rd_tgl_reg <= 1'b0;
			rd_data_reg <= '0;
		end else begin
			if (rd_push) begin
				rbuf_reg[rbuf_wp_reg] <= RD_DATA;
				rbuf_wp_reg <= ~rbuf_wp_reg;
			end
			if (rd_launch) begin
				rd_data_reg <= rbuf_reg[rbuf_rp_reg];
				rbuf_rp_reg <= ~rbuf_rp_reg;
				rd_tgl_reg <= ~rd_tgl_reg;
			end
			rbuf_cnt_reg <= rbuf_cnt_reg + 2'(rd_push ? 1 : 0) - 2'(rd_launch ? 1 : 0);
		end
	end
endmodule : lpi_mem_end
`default_nettype wire

//--- verilog/lpi_pkg.sv
// shared constants for the sdram pad interface ends
`default_nettype none
package lpi_pkg;
	localparam int CA_W = 10;
	localparam int LANE_W = 8;
	localparam int DQ_W_X16 = 16;
	localparam int DQ_W_X32 = 32;
	localparam int LANES_X16 = 2;
	localparam int LANES_X32 = 4;
	localparam int LINK_DIV = 4;
	localparam int BUF_DEPTH = 2;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
endpackage : lpi_pkg
`default_nettype wire

//--- verilog/lpi_link_if.sv
// pin-level link between memory controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface lpi_link_if #(
	parameter int DQ_W = 16,
	parameter int LANES = 2
);
	logic ck;
	logic clock_complement;
	logic cke;
	logic cs_n;
	logic [9:0] cmd_addr_bus;
	logic [DQ_W-1:0] dq_ctl_o;
	logic [DQ_W-1:0] dq_mem_o;
	logic dq_ctl_oe;
	logic dq_mem_oe;
	logic [LANES-1:0] dqs_ctl_o;
	logic [LANES-1:0] dqs_mem_o;
	logic dqs_ctl_oe;
	logic dqs_mem_oe;
	logic [LANES-1:0] write_byte_mask;
	// wire levels resolved from the enables; no driver reads as zero on dq and dqs, one on dqs_n
	logic [DQ_W-1:0] dq;
	logic [LANES-1:0] dqs;
	logic [LANES-1:0] dqs_n;
	assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
	assign dqs = dqs_mem_oe ? dqs_mem_o : (dqs_ctl_oe ? dqs_ctl_o : '0);
	assign dqs_n = ~dqs;
	modport ctrl (
		output ck, clock_complement, cke, cs_n, cmd_addr_bus,
		output dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe, write_byte_mask,
		input dq, dqs, dqs_n
	);
	modport mem (
		input ck, clock_complement, cke, cs_n, cmd_addr_bus, write_byte_mask,
		output dq_mem_o, dq_mem_oe, dqs_mem_o, dqs_mem_oe,
		input dq, dqs, dqs_n
	);
endinterface : lpi_link_if
`default_nettype wire

//--- verilog/lpi_ctrl_end.sv
// controller end: drives clock, commands and strobed write data
`timescale 1ns/1ps
`default_nettype none
module lpi_ctrl_end #(
	parameter int DQ_W = lpi_pkg::DQ_W_X16,
	parameter int LANES = lpi_pkg::LANES_X16
) (
	// link to the memory
	lpi_link_if.ctrl LINK,
	// user side
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CKE_REQ,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [lpi_pkg::CA_W-1:0] CMD_RISE,
	input wire logic [lpi_pkg::CA_W-1:0] CMD_FALL,
	input wire logic [1:0] CMD_OP,
	input wire logic [DQ_W-1:0] WR_DATA,
	input wire logic [LANES-1:0] WR_MASK
);
	import lpi_pkg::*;
	logic [1:0] div_reg;
	logic ck_reg;
	logic busy_reg;
	logic [CA_W-1:0] fall_reg;
	logic [1:0] op_reg;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			div_reg <= 2'h0;
			ck_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'(LINK_DIV / 2 - 1)) begin
				ck_reg <= ~ck_reg;
				div_reg <= 2'h0;
			end
		end
	end
	assign LINK.ck = ck_reg;
	assign LINK.clock_complement = ~ck_reg;
	assign CMD_READY = !busy_reg && ck_reg && div_reg == 2'h1;
	// rising ck word set before the rising edge, falling word one CLK after that edge
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			busy_reg <= 1'b0;
			LINK.cke <= 1'b0;
			LINK.cs_n <= 1'b1;
			LINK.cmd_addr_bus <= '0;
			LINK.dq_ctl_oe <= 1'b0;
			LINK.dqs_ctl_oe <= 1'b0;
			LINK.dq_ctl_o <= '0;
			LINK.dqs_ctl_o <= '0;
			LINK.write_byte_mask <= '0;
			fall_reg <= '0;
			op_reg <= OP_NONE;
		end else begin
			// enable moves only as ck falls, so it is settled at the next rising edge
			if (ck_reg && div_reg == 2'h1) begin
				LINK.cke <= CKE_REQ;
			end
			if (CMD_VALID && CMD_READY) begin
				LINK.cs_n <= 1'b0;
				LINK.cmd_addr_bus <= CMD_RISE;
				fall_reg <= CMD_FALL;
				op_reg <= CMD_OP;
				busy_reg <= 1'b1;
				LINK.dq_ctl_o <= WR_DATA;
				LINK.write_byte_mask <= WR_MASK;
				LINK.dq_ctl_oe <= CMD_OP == OP_WRITE;
				LINK.dqs_ctl_oe <= CMD_OP == OP_WRITE;
			end else if (busy_reg && ck_reg && div_reg == 2'h0) begin
				LINK.cmd_addr_bus <= fall_reg;
				LINK.dqs_ctl_o <= {LANES{op_reg == OP_WRITE}};
			end else if (busy_reg && ck_reg && div_reg == 2'h1) begin
				LINK.cs_n <= 1'b1;
				LINK.dqs_ctl_o <= '0;
				busy_reg <= 1'b0;
			end else if (!busy_reg && !ck_reg) begin
				LINK.dq_ctl_oe <= 1'b0;
				LINK.dqs_ctl_oe <= 1'b0;
			end
		end
	end
endmodule : lpi_ctrl_end
`default_nettype wire

//--- test/lpi_link_assertions.sv
// link-level checks between the two ends
`timescale 1ns/1ps
`default_nettype none
module lpi_link_assertions #(
	parameter int LANES = 2
) (
	// clock, reset
	input wire logic CLK,
	input wire logic RST_N,
	// link
	input wire logic ck,
	input wire logic clock_complement,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe,
	input wire logic dqs_ctl_oe,
	input wire logic dqs_mem_oe,
	input wire logic [LANES-1:0] dqs_mem_o
);
	// ****
	// properties
	// ****
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	ck_pair_a: assert property (clock_complement == ~ck) else $error("clock pair broken");
	ck_rate_a: assert property ($rose(ck) |=> ck ##1 !ck ##1 !ck ##1 ck)
		else $error("link clock period wrong");
	cs_edge_a: assert property ($changed(cs_n) |-> !ck) else $error("select moved ck high");
	cke_edge_a: assert property ($changed(cke) |-> !ck) else $error("enable moved ck high");
	dq_clash_a: assert property (!(dq_ctl_oe && dq_mem_oe)) else $error("data bus clash");
	dqs_clash_a: assert property (!(dqs_ctl_oe && dqs_mem_oe)) else $error("strobe clash");
	lane_strobe_a: assert property (dqs_mem_oe |-> dqs_mem_o == {LANES{dqs_mem_o[0]}})
		else $error("lane strobes differ");
	cke_off_a: assert property (!cke [*8] |-> !dq_mem_oe && !dqs_mem_oe)
		else $error("driving while enable low");
endmodule : lpi_link_assertions
`default_nettype wire

//--- test/tb.sv
// self-checking bench joining controller end and memory end
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lpi_pkg::*;
	// ****
	// harness
	// ****
	logic CLK = 0, RST_N = 0, cke_req = 0, c_valid = 0, m_ready = 0, rd_valid = 0;
	logic c_ready, m_valid, m_wvalid, rd_ready, m_ps;
	logic [9:0] c_rise = '0, c_fall = '0;
	logic [1:0] c_op = OP_NONE, c_wmask = '0, m_store;
	logic [15:0] c_wdata = '0, rd_data = '0, m_wdata;
	logic [21:0] m_code;
	logic [15:0] rd_exp = '0;
	logic [21:0] cq[$];
	logic [17:0] wq[$];
	int err_count = 0;
	int n_checks = 0;
	int seed = 34002;
	int j;
	always #2.5 CLK = ~CLK;
	lpi_link_if lk ();
	lpi_ctrl_end i_lpi_ctrl_end (.LINK(lk), .CLK(CLK), .RST_N(RST_N), .CKE_REQ(cke_req),
		.CMD_VALID(c_valid), .CMD_READY(c_ready), .CMD_RISE(c_rise), .CMD_FALL(c_fall),
		.CMD_OP(c_op), .WR_DATA(c_wdata), .WR_MASK(c_wmask));
	lpi_mem_end i_lpi_mem_end (.LINK(lk), .CLK(CLK), .RST_N(RST_N), .CMD_VALID(m_valid),
		.CMD_READY(m_ready), .CMD_CODE(m_code), .WR_DATA(m_wdata), .WR_STORE(m_store),
		.WR_VALID(m_wvalid), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready),
		.POWER_SAVE(m_ps));
	lpi_link_assertions i_chk (.CLK(CLK), .RST_N(RST_N), .ck(lk.ck), .cke(lk.cke),
		.clock_complement(lk.clock_complement), .cs_n(lk.cs_n), .dq_ctl_oe(lk.dq_ctl_oe),
		.dq_mem_oe(lk.dq_mem_oe), .dqs_ctl_oe(lk.dqs_ctl_oe), .dqs_mem_oe(lk.dqs_mem_oe),
		.dqs_mem_o(lk.dqs_mem_o));
	function automatic logic [21:0] exp_code(logic [9:0] r, logic [9:0] f);
		return {1'b1, 1'b0, f, r};
	endfunction : exp_code
	task automatic check(string what, logic [21:0] seen, logic [21:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// held until accepted or 60 cycles pass; the expectation is queued once the wait ends
	task automatic send(logic [1:0] op, logic [15:0] d, logic [1:0] m);
		logic [9:0] r, f;
		logic [15:0] v;
		int k;
		r = 10'($random(seed));
		f = 10'($random(seed));
		@(posedge CLK);
		c_valid <= 1'b1;
		c_rise <= r;
		c_fall <= f;
		c_op <= op;
		c_wdata <= d;
		c_wmask <= m;
		for (k = 0; k < 60; k++) begin
			@(negedge CLK);
			if (c_ready) break;
		end
		if (k == 60) err_count++;
		@(posedge CLK);
		c_valid <= 1'b0;
		cq.push_back(exp_code(r, f));
		if (op == OP_WRITE) wq.push_back({~m, d});
		if (op == OP_READ) begin
			v = 16'($random(seed));
			check("rd ready", 22'(rd_ready), 22'h1);
			rd_exp = v;
			rd_data <= v;
			rd_valid <= 1'b1;
			@(posedge CLK);
			rd_valid <= 1'b0;
			// memory end drives the data bus for one link cycle; keep writes away
			repeat (24) @(posedge CLK);
		end
	endtask : send
	// receiver stalls at random so the two-entry buffer fills
	always @(posedge CLK) begin
		m_ready <= 1'($random(seed));
		if (RST_N && lk.dq_mem_oe) check("rd data", 22'(lk.dq), 22'(rd_exp));
		if (RST_N && m_valid && m_ready) check("cmd", m_code, cq.size() ? cq.pop_front() : 'x);
		if (RST_N && m_wvalid) check("wr", {m_store, m_wdata}, wq.size() ? wq.pop_front() : 'x);
	end
	initial begin
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		cke_req <= 1'b1;
		repeat (20) @(posedge CLK);
		send(OP_WRITE, 16'h0000, 2'h0);
		send(OP_WRITE, 16'hffff, 2'h3);
		send(OP_WRITE, 16'ha5c3, 2'h1);
		send(OP_WRITE, 16'h3c5a, 2'h2);
		for (j = 0; j < 30; j++) send(2'(($random(seed) & 255) % 3), 16'($random(seed)), 2'($random(seed)));
		repeat (60) @(negedge CLK);
		cke_req <= 1'b0;
		for (j = 0; j < 60 && m_ps !== 1'b1; j++) @(negedge CLK);
		check("power save", 22'(m_ps), 22'h1);
		cke_req <= 1'b1;
		for (j = 0; j < 60 && m_ps !== 1'b0; j++) @(negedge CLK);
		check("wake", 22'(m_ps), 22'h0);
		send(OP_WRITE, 16'h1234, 2'h1);
		repeat (80) @(negedge CLK);
		check("pending", 22'(cq.size() + wq.size()), 22'h0);
		wrap_up();
	end
	initial begin
		#50000;
		err_count++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
